// ===== core/sarrd_fifo.sv
`timescale 1ns/1ps
module sarrd_fifo
    import sarrd_pkg::*;
#(
    parameter int WIDTH = SAR_BITS,
    parameter int DEPTH = FIFO_DEPTH_RST
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    wire logic full;
    wire logic empty;
    wire logic do_write;
    wire logic do_read;

    // Extra pointer bit tells full from empty
    assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                  (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    assign empty = (wr_ptr == rd_ptr);
    assign do_write = in_valid_i && !full;
    assign do_read = out_ready_i && !empty;
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    // Storage
    always_ff @(posedge clk_i) begin
        if (do_write) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers; flush empties the queue
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_write) begin
                wr_ptr <= wr_ptr + (AW+1)'(1);
            end
            if (do_read) begin
                rd_ptr <= rd_ptr + (AW+1)'(1);
            end
        end
    end

endmodule

// ===== core/sarrd_pkg.sv
package sarrd_pkg;

    // Result word and conversion sequencing
    localparam int SAR_BITS = 16;
    localparam int CLK_MHZ = 200;
    localparam int CONV_MAX_NS = 63;
    localparam int CONV_MAX_CYC = (CONV_MAX_NS * CLK_MHZ) / 1000;
    localparam int SYNC_CYC = 3;
    localparam logic [3:0] READY_CYC = 4'(CONV_MAX_CYC - SYNC_CYC);
    localparam logic [2:0] LAST_PAIR = 3'h7;
    localparam logic [3:0] TOP_BIT = 4'hF;

    // Serial shifting and result buffer depth
    localparam logic [3:0] LEFT_ONE_LANE = 4'hE;
    localparam logic [3:0] LEFT_TWO_LANE = 4'h6;
    localparam logic [15:0] TEST_PATTERN_RST = 16'hA53C;
    localparam int FIFO_DEPTH_RST = 16;

    // Reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [3:0] COUNT_RST = 4'h0;
    localparam logic LANE_RST = 1'b0;

    // Converter sequence
    typedef enum logic [1:0] {
        ST_ACQUIRE = 2'b00,
        ST_CONVERT = 2'b01,
        ST_PUSH = 2'b10
    } sarrd_state_e;

    // Static pin settings as seen by the link logic
    typedef struct packed {
        logic run;
        logic dual;
        logic pattern;
    } sarrd_cfg_s;

    // One conversion result
    typedef struct packed {
        logic [SAR_BITS-1:0] code;
    } sarrd_word_s;

    localparam sarrd_cfg_s CFG_RST = '{run: 1'b0, dual: 1'b0, pattern: 1'b0};

endpackage

// ===== core/sarrd_top.sv
`timescale 1ns/1ps
module sarrd_top
    import sarrd_pkg::*;
#(
    parameter logic [15:0] TEST_PATTERN = TEST_PATTERN_RST,
    parameter int FIFO_DEPTH = FIFO_DEPTH_RST
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic link_clk_i,
    input wire logic convert_start_i,
    input wire logic power_down_n_i,
    input wire logic pattern_force_i,
    input wire logic dual_lane_select_i,
    input wire logic [SAR_BITS-1:0] analog_level_i,
    output logic busy_o,
    output logic serial_out_primary_o,
    output logic serial_out_primary_oe_o,
    output logic serial_out_secondary_o,
    output logic serial_out_secondary_oe_o,
    output logic echo_clock_out_o
);

    // ---- Core domain: pin synchronisers ----
    logic cnv_meta;
    logic cnv_sync;
    logic cnv_last;
    logic pd_meta;
    logic pd_sync;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            cnv_meta <= 1'b0;
            cnv_sync <= 1'b0;
            cnv_last <= 1'b0;
            pd_meta <= 1'b0;
            pd_sync <= 1'b0;
        end else begin
            cnv_meta <= convert_start_i;
            cnv_sync <= cnv_meta;
            cnv_last <= cnv_sync;
            pd_meta <= power_down_n_i;
            pd_sync <= pd_meta;
        end
    end

    // Start edge and power state
    wire logic cnv_rise;
    wire logic core_run;
    assign cnv_rise = cnv_sync && !cnv_last;
    assign core_run = pd_sync;

    // ---- Core domain: converter sequence ----
    sarrd_state_e state;
    sarrd_state_e next_state;
    logic [SAR_BITS-1:0] held;
    logic [SAR_BITS-1:0] acc;
    logic [2:0] pair;
    logic [3:0] tick;
    logic push_valid;
    sarrd_word_s push_word;
    wire logic fifo_in_ready;

    // One SAR decision: keep the trial bit if the held level reaches it
    function automatic logic [SAR_BITS-1:0] sar_decide(
        input logic [SAR_BITS-1:0] level,
        input logic [SAR_BITS-1:0] base,
        input logic [3:0] bit_pos
    );
        logic [SAR_BITS-1:0] trial;
        trial = base | (16'h0001 << bit_pos);
        return (level >= trial) ? trial : base;
    endfunction

    // Two decisions per clock so 16 bits fit the conversion window
    wire logic [3:0] bit_hi;
    wire logic [3:0] bit_lo;
    wire logic [SAR_BITS-1:0] acc_hi;
    wire logic [SAR_BITS-1:0] next_acc;
    assign bit_hi = TOP_BIT - {pair, 1'b0};
    assign bit_lo = bit_hi - 4'h1;
    assign acc_hi = sar_decide(held, acc, bit_hi);
    assign next_acc = sar_decide(held, acc_hi, bit_lo);

    // A new start is taken only while acquiring with room to store it
    wire logic take_start;
    wire logic sar_done;
    wire logic ready_now;
    assign take_start = cnv_rise && core_run && fifo_in_ready;
    assign sar_done = (pair == LAST_PAIR);
    assign ready_now = (tick == READY_CYC);

    // Next-state decode
    always_comb begin
        next_state = state;
        unique case (state)
            ST_ACQUIRE: begin
                if (take_start) begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (ready_now) begin
                    next_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                next_state = ST_ACQUIRE;
            end
            default: begin
                next_state = ST_ACQUIRE;
            end
        endcase
        if (!core_run) begin
            next_state = ST_ACQUIRE;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            state <= ST_ACQUIRE;
        end else begin
            state <= next_state;
        end
    end

    // Hold the input at the start edge
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            held <= WORD_RST;
        end else if (state == ST_ACQUIRE && take_start) begin
            held <= analog_level_i;
        end
    end

    // Approximation register and pair counter
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || state == ST_ACQUIRE) begin
            acc <= WORD_RST;
            pair <= 3'h0;
        end else if (state == ST_CONVERT && !sar_done) begin
            acc <= next_acc;
            pair <= pair + 3'h1;
        end else if (state == ST_CONVERT) begin
            acc <= next_acc;
        end
    end

    // Conversion time counter
    always_ff @(posedge clk_i) begin
        if (!reset_n_i || state != ST_CONVERT) begin
            tick <= COUNT_RST;
        end else begin
            tick <= tick + 4'h1;
        end
    end

    // Result goes to the buffer once, flipped to two's complement
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            push_valid <= 1'b0;
            push_word <= '0;
        end else begin
            push_valid <= (state == ST_CONVERT) && ready_now && core_run;
            push_word.code <= {~acc[SAR_BITS-1], acc[SAR_BITS-2:0]};
        end
    end

    // Busy flag
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            busy_o <= 1'b0;
        end else begin
            busy_o <= (next_state != ST_ACQUIRE);
        end
    end

    // ---- Result buffer ----
    wire logic fifo_out_valid;
    wire logic fifo_out_ready;
    wire logic [SAR_BITS-1:0] fifo_out_data;

    sarrd_fifo #(
        .WIDTH(SAR_BITS),
        .DEPTH(FIFO_DEPTH)
    ) i_sarrd_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .flush_i(!core_run),
        .in_valid_i(push_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_word.code),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ---- Word crossing to the link: toggle handshake ----
    logic pending;
    logic req_tog;
    logic [SAR_BITS-1:0] xfer_word;
    logic ack_meta;
    logic ack_sync;
    logic ack_tog;

    wire logic fifo_take;
    wire logic ack_seen;
    assign fifo_out_ready = core_run && !pending;
    assign fifo_take = fifo_out_valid && fifo_out_ready;
    assign ack_seen = pending && (ack_sync == req_tog);

    // Ack return synchroniser
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            ack_meta <= ack_tog;
            ack_sync <= ack_meta;
        end
    end

    // Word stays still from the request toggle until acknowledged
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            pending <= 1'b0;
            req_tog <= 1'b0;
            xfer_word <= WORD_RST;
        end else if (fifo_take) begin
            pending <= 1'b1;
            req_tog <= ~req_tog;
            xfer_word <= fifo_out_data;
        end else if (ack_seen) begin
            pending <= 1'b0;
        end
    end

    // ---- Link domain: synchronisers on the shift clock ----
    logic lrst_meta;
    logic lrst_sync;
    logic lreq_meta;
    logic lreq_sync;
    sarrd_cfg_s cfg_meta;
    sarrd_cfg_s cfg;

    always_ff @(posedge link_clk_i) begin
        lrst_meta <= reset_n_i;
        lrst_sync <= lrst_meta;
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_sync) begin
            lreq_meta <= 1'b0;
            lreq_sync <= 1'b0;
            cfg_meta <= CFG_RST;
            cfg <= CFG_RST;
        end else begin
            lreq_meta <= req_tog;
            lreq_sync <= lreq_meta;
            cfg_meta <= '{run: power_down_n_i,
                          dual: dual_lane_select_i,
                          pattern: pattern_force_i};
            cfg <= cfg_meta;
        end
    end

    // ---- Link domain: shifter ----
    logic [SAR_BITS-1:0] shift_reg;
    logic [3:0] bits_left;
    logic shifting;

    wire logic link_run;
    wire logic new_word;
    wire logic [SAR_BITS-1:0] load_word;
    wire logic [SAR_BITS-1:0] src_word;
    assign link_run = lrst_sync && cfg.run;
    assign new_word = !shifting && (lreq_sync != ack_tog);
    assign load_word = cfg.pattern ? TEST_PATTERN : xfer_word;
    assign src_word = shifting ? shift_reg : load_word;

    // Ack toggles once the word has been loaded into the shifter
    always_ff @(posedge link_clk_i) begin
        if (!lrst_sync) begin
            ack_tog <= 1'b0;
        end else if (new_word) begin
            ack_tog <= lreq_sync;
        end
    end

    // Each shift clock moves one or two bits out, MSB first
    always_ff @(posedge link_clk_i) begin
        if (!link_run) begin
            shift_reg <= WORD_RST;
            bits_left <= COUNT_RST;
            shifting <= 1'b0;
        end else if (new_word || shifting) begin
            if (cfg.dual) begin
                shift_reg <= {src_word[SAR_BITS-3:0], 2'b00};
            end else begin
                shift_reg <= {src_word[SAR_BITS-2:0], 1'b0};
            end
            if (!shifting) begin
                bits_left <= cfg.dual ? LEFT_TWO_LANE : LEFT_ONE_LANE;
                shifting <= 1'b1;
            end else begin
                bits_left <= bits_left - 4'h1;
                shifting <= (bits_left != COUNT_RST);
            end
        end
    end

    // Lane data registers
    wire logic active_step;
    assign active_step = link_run && (new_word || shifting);

    always_ff @(posedge link_clk_i) begin
        if (!active_step) begin
            serial_out_primary_o <= LANE_RST;
            serial_out_secondary_o <= LANE_RST;
        end else begin
            serial_out_primary_o <= src_word[SAR_BITS-1];
            serial_out_secondary_o <= cfg.dual &&
                                      src_word[SAR_BITS-2];
        end
    end

    // Driver enables: secondary only in dual-lane mode
    always_ff @(posedge link_clk_i) begin
        if (!lrst_sync) begin
            serial_out_primary_oe_o <= 1'b0;
            serial_out_secondary_oe_o <= 1'b0;
        end else begin
            serial_out_primary_oe_o <= cfg.run;
            serial_out_secondary_oe_o <= cfg.run && cfg.dual;
        end
    end

    // Echo clock flips on every shift edge, in step with the lanes
    always_ff @(posedge link_clk_i) begin
        if (!link_run) begin
            echo_clock_out_o <= 1'b0;
        end else begin
            echo_clock_out_o <= ~echo_clock_out_o;
        end
    end

endmodule

// ===== verif/sarrd_rx.sv
`timescale 1ns/1ps
module sarrd_rx (
    input wire logic link_clk_i,
    input wire logic clear_i,
    input wire logic primary_i,
    input wire logic secondary_i,
    output logic [95:0] hist_p_o,
    output logic [95:0] hist_s_o
);
    // Receiver latches both lanes mid-bit, MSB arrives first
    always @(negedge link_clk_i) begin
        if (clear_i) begin
            hist_p_o <= '0;
            hist_s_o <= '0;
        end else begin
            hist_p_o <= {hist_p_o[94:0], primary_i};
            hist_s_o <= {hist_s_o[94:0], secondary_i};
        end
    end
endmodule

// ===== verif/sarrd_top_properties.sv
`timescale 1ns/1ps
module sarrd_top_properties (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic link_clk_i,
    input wire logic convert_start_i,
    input wire logic power_down_n_i,
    input wire logic dual_lane_select_i,
    input wire logic busy_o,
    input wire logic serial_out_primary_oe_o,
    input wire logic serial_out_secondary_o,
    input wire logic serial_out_secondary_oe_o,
    input wire logic echo_clock_out_o
);
    // Conversion start and length in the core domain
    AST_START_TAKEN: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(convert_start_i) && !busy_o && power_down_n_i
        |-> ##[1:5] busy_o)
        else $error("start edge not taken");
    AST_START_CAUSE: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(busy_o) |-> $past(convert_start_i, 2))
        else $error("conversion without start edge");
    AST_BUSY_LEN: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        $rose(busy_o) |-> busy_o [*8] ##1 busy_o [*3] ##1 !busy_o)
        else $error("conversion length wrong");
    AST_PD_BUSY: assert property (
        @(posedge clk_i) disable iff (!reset_n_i)
        (!power_down_n_i) [*6] |-> !busy_o)
        else $error("converting in power-down");
    // Lane drivers and echo in the link domain
    AST_PD_LINK: assert property (
        @(posedge link_clk_i) disable iff (!reset_n_i)
        (!power_down_n_i) [*6] |-> !serial_out_primary_oe_o
        && !serial_out_secondary_oe_o && !echo_clock_out_o)
        else $error("link active in power-down");
    AST_PRI_ON: assert property (
        @(posedge link_clk_i) disable iff (!reset_n_i)
        power_down_n_i [*6] |-> serial_out_primary_oe_o)
        else $error("primary lane not driven");
    AST_SEC_OFF: assert property (
        @(posedge link_clk_i) disable iff (!reset_n_i)
        (!dual_lane_select_i) [*6] |-> !serial_out_secondary_oe_o
        && !serial_out_secondary_o)
        else $error("secondary lane active in single mode");
    AST_SEC_ON: assert property (
        @(posedge link_clk_i) disable iff (!reset_n_i)
        (dual_lane_select_i && power_down_n_i) [*6]
        |-> serial_out_secondary_oe_o)
        else $error("secondary lane not driven in dual mode");
    AST_ECHO: assert property (
        @(posedge link_clk_i) disable iff (!reset_n_i)
        serial_out_primary_oe_o [*3]
        |-> echo_clock_out_o != $past(echo_clock_out_o))
        else $error("echo clock does not follow shift clock");
endmodule
bind sarrd_top sarrd_top_properties i_sarrd_top_properties (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
    .convert_start_i(convert_start_i), .power_down_n_i(power_down_n_i),
    .dual_lane_select_i(dual_lane_select_i), .busy_o(busy_o),
    .serial_out_primary_oe_o(serial_out_primary_oe_o),
    .serial_out_secondary_o(serial_out_secondary_o),
    .serial_out_secondary_oe_o(serial_out_secondary_oe_o),
    .echo_clock_out_o(echo_clock_out_o));

// ===== verif/tb_sarrd_top.sv
`timescale 1ns/1ps
module tb_sarrd_top;
    import sarrd_pkg::*;
    localparam logic [15:0] TP = 16'h5AC3;
    logic clk_i = 0, link_clk_i = 0, reset_n_i = 0, clr = 0;
    logic convert_start_i = 0, power_down_n_i = 1;
    logic pattern_force_i = 0, dual_lane_select_i = 0;
    logic [15:0] analog_level_i = 16'h8000;
    logic busy_o, p_o, p_oe, s_o, s_oe, echo;
    logic [95:0] hp, hs;
    logic [31:0] seed = 32'h45D3888E;
    int err_total = 0, n_tests = 0;

    // Core clock and unrelated shift clock
    always #2.5 clk_i = ~clk_i;
    initial begin
        #7.3;
        forever #24 link_clk_i = ~link_clk_i;
    end

    sarrd_top #(.TEST_PATTERN(TP)) i_sarrd_top (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .link_clk_i(link_clk_i),
        .convert_start_i(convert_start_i), .power_down_n_i(power_down_n_i),
        .pattern_force_i(pattern_force_i),
        .dual_lane_select_i(dual_lane_select_i),
        .analog_level_i(analog_level_i), .busy_o(busy_o),
        .serial_out_primary_o(p_o), .serial_out_primary_oe_o(p_oe),
        .serial_out_secondary_o(s_o), .serial_out_secondary_oe_o(s_oe),
        .echo_clock_out_o(echo));
    sarrd_rx i_sarrd_rx (.link_clk_i(link_clk_i), .clear_i(clr),
        .primary_i(p_o), .secondary_i(s_o), .hist_p_o(hp), .hist_s_o(hs));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    // Bit stream one lane should carry for the given words
    function automatic logic [95:0] lane(input logic [15:0] w[2],
        input int n, input logic dual, input logic sec);
        logic [95:0] r;
        r = '0;
        for (int i = 0; i < n; i++)
            for (int b = 15; b >= 0; b--)
                if (dual ? (b % 2 == !sec) : !sec)
                    r = {r[94:0], w[i][b]};
        return r;
    endfunction

    task automatic chk(input string nm, input logic [95:0] e,
        input logic [95:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Issue n starts gap cycles apart, expect nexp words on the lanes
    task automatic run(input int n, input int gap, input int nexp);
        logic [15:0] w[2];
        logic [95:0] ep, es, gp, gs;
        repeat (4) @(posedge link_clk_i);
        @(negedge clk_i) clr = 1;
        repeat (2) @(posedge link_clk_i);
        @(negedge clk_i) clr = 0;
        for (int i = 0; i < n; i++) begin
            seed = xs(seed);
            // Every fifth check round starts from a full-scale corner
            analog_level_i = (n_tests % 5 == 0) ? {16{seed[31]}} : seed[15:0];
            // Two's complement code from the offset-binary level by MSB flip
            w[i] = pattern_force_i ? TP : analog_level_i ^ 16'h8000;
            convert_start_i = 1;
            repeat (6) @(negedge clk_i);
            convert_start_i = 0;
            repeat (gap - 6) @(negedge clk_i);
        end
        repeat (45) @(posedge link_clk_i);
        ep = lane(w, nexp, dual_lane_select_i, 1'b0);
        es = lane(w, nexp, dual_lane_select_i, 1'b1);
        gp = hp;
        gs = hs;
        for (int k = 0; k < 64; k++)
            if ((ep << k) === hp && (es << k) === hs) begin
                gp = ep;
                gs = es;
            end
        chk("lane_primary", ep, gp);
        chk("lane_secondary", es, gs);
        chk("secondary_oe", 96'(dual_lane_select_i), 96'(s_oe));
    endtask

    // Watchdog
    initial begin
        #200000;
        err_total++;
        final_report();
    end

    // Reset, mode table with refused and queued starts, power-down
    initial begin
        repeat (20) @(negedge clk_i);
        reset_n_i = 1;
        repeat (10) @(negedge clk_i);
        for (int t = 0; t < 12; t++) begin
            @(negedge clk_i);
            dual_lane_select_i = (t / 2) % 2;
            pattern_force_i = (t % 4 == 3) || (t == 8);
            run(t % 3 == 0 ? 1 : 2, t % 3 == 1 ? 8 : 24, t % 3 == 2 ? 2 : 1);
            $display("test %0d done", t);
        end
        @(negedge clk_i) power_down_n_i = 0;
        repeat (8) @(posedge link_clk_i);
        @(negedge clk_i) convert_start_i = 1;
        repeat (6) @(negedge clk_i);
        chk("busy_power_down", 96'(0), 96'(busy_o));
        chk("link_power_down", 96'(0), 96'({p_oe, s_oe, echo}));
        convert_start_i = 0;
        power_down_n_i = 1;
        run(1, 24, 1);
        $display("test power_down done");
        final_report();
    end
endmodule
